//--- hw/rtc_pkg.sv
// Constants, types and field layouts for the BCD calendar clock core.
// Notes on behaviour
// RULE_01 - weekday counts 0 Sunday through 6 Saturday, then wraps.
// RULE_02 - day rolls after 31 or 30 depending on month.
// RULE_03 - years divisible by four have February 29, otherwise 28.
// RULE_04 - all fields from seconds up are writable; counting resumes from written value.
// RULE_05 - counter runs only while enable bit 7 is set, also during adjustments.
// RULE_06 - any minutes/seconds write clears both prescaler stages.
// RULE_07 - a counter write takes effect in the cycle of the write.
// RULE_08 - half-second bit is read-only; low seconds write resets it.
// RULE_09 - sync flag bit 4 reads 0 while access is safe from rollover.
// RULE_10 - software reads each register twice and compares results.
// RULE_11 - counter writes accepted only while write-enable bit 5 is set.
// RULE_12 - write-enable set needs 0x55 then 0xAA then set within window.
// RULE_13 - software keeps write-enable clear except while updating.
// RULE_14 - value pointer bits 1:0 select min/sec, wday/hr, month/day, none/year.
// RULE_15 - each value-high access decrements value pointer until 00.
// RULE_16 - alarm pointer bits 1:0 select alarm min/sec, wday/hr, month/day, none.
// RULE_17 - each alarm-high access decrements alarm pointer until 00.
// RULE_18 - signed 8-bit calibration times four applied once per minute.
// RULE_19 - negative calibration removes pulses, positive adds them.
// RULE_20 - software writes calibration when disabled or just after second pulse.
// RULE_21 - enable bit and value window writes ignored while write-enable clear.
// RULE_22 - 23:59:59 rolls to 00:00:00, Dec 31 to Jan 1, year 99 to 00.
// RULE_23 - every BCD digit carries at ten.
// RULE_24 - any other write between unlock steps abandons the sequence.
// RULE_25 - written values land atomically; no field is left half updated.
package rtc_pkg;

    // register selects on the cpu port
    typedef enum logic [2:0] {
        SEL_CLOCK_CFG = 3'h0,
        SEL_ALARM_CFG = 3'h1,
        SEL_VALUE_HIGH = 3'h2,
        SEL_VALUE_LOW = 3'h3,
        SEL_ALARM_HIGH = 3'h4,
        SEL_ALARM_LOW = 3'h5,
        SEL_CALIB = 3'h6,
        SEL_UNLOCK_KEY = 3'h7
    } reg_sel_t;

    typedef enum logic [1:0] {
        UNLOCK_IDLE = 2'b00,
        UNLOCK_FIRST = 2'b01,
        UNLOCK_OPEN = 2'b10
    } unlock_state_t;

    typedef struct packed {
        logic wr;
        logic rd;
        reg_sel_t sel;
        logic [7:0] data;
    } cpu_req_t;

    typedef struct packed {
        logic [7:0] year;
        logic [7:0] month;
        logic [7:0] day;
        logic [7:0] weekday;
        logic [7:0] hours;
        logic [7:0] minutes;
        logic [7:0] seconds;
    } calendar_t;

    // configuration bit positions
    localparam int CFG_ENABLE_BIT = 7;
    localparam int CFG_WREN_BIT = 5;
    localparam int CFG_SYNC_BIT = 4;
    localparam int CFG_HALF_BIT = 3;

    // pointer codes
    localparam logic [1:0] PTR_MIN_SEC = 2'h0;
    localparam logic [1:0] PTR_WDAY_HOUR = 2'h1;
    localparam logic [1:0] PTR_MONTH_DAY = 2'h2;
    localparam logic [1:0] PTR_YEAR = 2'h3;

    // unlock keys and window
    localparam logic [7:0] KEY_FIRST = 8'h55;
    localparam logic [7:0] KEY_SECOND = 8'hAA;
    localparam int UNLOCK_NS = 100;
    localparam int CLK_PERIOD_NS = 25;
    localparam int UNLOCK_CYCLES_INT = UNLOCK_NS / CLK_PERIOD_NS;
    localparam logic [2:0] UNLOCK_CYCLES = 3'(UNLOCK_CYCLES_INT);

    // field masks applied on writes
    localparam logic [7:0] MASK_SEC_MIN = 8'h7F;
    localparam logic [7:0] MASK_HOUR_DAY = 8'h3F;
    localparam logic [7:0] MASK_WEEKDAY = 8'h07;
    localparam logic [7:0] MASK_MONTH = 8'h1F;

    // BCD limits
    localparam logic [7:0] LAST_SEC_MIN = 8'h59;
    localparam logic [7:0] LAST_HOUR = 8'h23;
    localparam logic [7:0] LAST_WEEKDAY = 8'h06;
    localparam logic [7:0] LAST_MONTH = 8'h12;
    localparam logic [7:0] LAST_YEAR = 8'h99;
    localparam logic [7:0] DAY_31 = 8'h31;
    localparam logic [7:0] DAY_30 = 8'h30;
    localparam logic [7:0] DAY_29 = 8'h29;
    localparam logic [7:0] DAY_28 = 8'h28;
    localparam logic [7:0] FIRST_ZERO = 8'h00;
    localparam logic [7:0] FIRST_ONE = 8'h01;
    localparam logic [7:0] MONTH_FEB = 8'h02;

    // prescaler: 16384 ticks per half second, flag raised near the rollover
    localparam int PRESC_W = 14;
    localparam logic [13:0] SYNC_START = 14'h3FE0;
    localparam logic signed [9:0] ADJ_ZERO = 10'sh000;

    // reset calendar: 2000-01-01, Saturday, 00:00:00
    localparam calendar_t CAL_RESET = '{8'h00, 8'h01, 8'h01, 8'h06, 8'h00, 8'h00, 8'h00};

endpackage

//--- hw/bcd_calendar_clock_core.sv
// BCD calendar clock with pointer windows, keyed write unlock and drift calibration.
module bcd_calendar_clock_core (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // 32.768 kHz tick, one cycle per crystal pulse
    input wire logic crystal_tick,
    // cpu register access
    input rtc_pkg::cpu_req_t cpu_req,
    output logic [7:0] rdata,
    // status
    output logic clock_module_enable,
    output logic counter_write_enable,
    output logic safe_access_window_flag,
    output logic half_second,
    output logic second_pulse
);

    rtc_pkg::calendar_t cal;
    rtc_pkg::calendar_t next_cal;
    rtc_pkg::unlock_state_t unlock_state;
    logic [2:0] unlock_count;
    logic [1:0] value_window_pointer;
    logic [1:0] alarm_window_pointer;
    logic [5:0] alarm_cfg_upper;
    logic [7:0] drift_calibration_register;
    logic [7:0] alarm_minutes;
    logic [7:0] alarm_seconds;
    logic [7:0] alarm_weekday;
    logic [7:0] alarm_hours;
    logic [7:0] alarm_month;
    logic [7:0] alarm_day;
    logic [13:0] presc;
    logic signed [9:0] adj;
    logic [14:0] presc_sum;
    logic [1:0] presc_step;
    logic sec_tick;
    logic minute_roll;
    logic wr_cfg;
    logic wr_key;
    logic wr_vh;
    logic wr_vl;
    logic wr_ah;
    logic wr_al;
    logic acc_vh;
    logic acc_ah;
    logic wr_counter;
    logic clear_presc;

    assign wr_cfg = cpu_req.wr && cpu_req.sel == rtc_pkg::SEL_CLOCK_CFG;
    assign wr_key = cpu_req.wr && cpu_req.sel == rtc_pkg::SEL_UNLOCK_KEY;
    assign wr_vh = cpu_req.wr && cpu_req.sel == rtc_pkg::SEL_VALUE_HIGH;
    assign wr_vl = cpu_req.wr && cpu_req.sel == rtc_pkg::SEL_VALUE_LOW;
    assign wr_ah = cpu_req.wr && cpu_req.sel == rtc_pkg::SEL_ALARM_HIGH;
    assign wr_al = cpu_req.wr && cpu_req.sel == rtc_pkg::SEL_ALARM_LOW;
    assign acc_vh = (cpu_req.wr || cpu_req.rd) && cpu_req.sel == rtc_pkg::SEL_VALUE_HIGH;
    assign acc_ah = (cpu_req.wr || cpu_req.rd) && cpu_req.sel == rtc_pkg::SEL_ALARM_HIGH;
    assign wr_counter = counter_write_enable && (wr_vh || wr_vl); // RULE_11 RULE_21
    assign clear_presc = wr_counter && value_window_pointer == rtc_pkg::PTR_MIN_SEC; // RULE_06

    // one BCD step: wraps to first after last, digits carry at ten
    function automatic logic [7:0] bcd_step(input logic [7:0] v, input logic [7:0] last,
                                            input logic [7:0] first);
        logic [7:0] r;
        r = v;
        if (v == last)
            r = first;
        else if (v[3:0] == 4'h9) // RULE_23
            r = {v[7:4] + 4'h1, 4'h0};
        else
            r = {v[7:4], v[3:0] + 4'h1};
        return r;
    endfunction

    function automatic logic is_leap(input logic [7:0] y);
        logic r;
        r = 1'b0;
        if (!y[4])
            r = y[3:0] == 4'h0 || y[3:0] == 4'h4 || y[3:0] == 4'h8;
        else
            r = y[3:0] == 4'h2 || y[3:0] == 4'h6;
        return r;
    endfunction

    function automatic logic [7:0] last_day(input logic [7:0] m, input logic [7:0] y);
        logic [7:0] r;
        r = rtc_pkg::DAY_31;
        case (m)
            8'h04, 8'h06, 8'h09, 8'h11: r = rtc_pkg::DAY_30; // RULE_02
            8'h02: r = is_leap(y) ? rtc_pkg::DAY_29 : rtc_pkg::DAY_28; // RULE_03
            default: r = rtc_pkg::DAY_31;
        endcase
        return r;
    endfunction

    // crystal prescaler with calibration: positive adjust doubles a tick, negative drops one
    always_comb
    begin
        presc_step = 2'd0;
        if (clock_module_enable && crystal_tick) // RULE_05
        begin
            if (adj > rtc_pkg::ADJ_ZERO)
                presc_step = 2'd2; // RULE_19
            else if (adj < rtc_pkg::ADJ_ZERO)
                presc_step = 2'd0; // RULE_19
            else
                presc_step = 2'd1;
        end
        presc_sum = {1'b0, presc} + {13'h0, presc_step};
        sec_tick = presc_sum[rtc_pkg::PRESC_W] && half_second;
        minute_roll = sec_tick && cal.seconds == rtc_pkg::LAST_SEC_MIN;
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            presc <= '0;
            half_second <= 1'b0;
        end
        else if (clear_presc) // RULE_06 RULE_08
        begin
            presc <= '0;
            half_second <= 1'b0;
        end
        else
        begin
            presc <= presc_sum[rtc_pkg::PRESC_W-1:0];
            if (presc_sum[rtc_pkg::PRESC_W])
                half_second <= !half_second;
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            adj <= rtc_pkg::ADJ_ZERO;
        else if (minute_roll)
            adj <= $signed({{2{drift_calibration_register[7]}}, drift_calibration_register}) <<< 2; // RULE_18
        else if (clock_module_enable && crystal_tick && adj > rtc_pkg::ADJ_ZERO)
            adj <= adj - 10'sd1;
        else if (clock_module_enable && crystal_tick && adj < rtc_pkg::ADJ_ZERO)
            adj <= adj + 10'sd1;
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            second_pulse <= 1'b0;
        else
            second_pulse <= sec_tick;
    end

    // calendar advance, then same-cycle cpu write overrides the addressed field of the selected pair
    always_comb
    begin
        next_cal = cal;
        if (sec_tick)
        begin
            next_cal.seconds = bcd_step(cal.seconds, rtc_pkg::LAST_SEC_MIN, rtc_pkg::FIRST_ZERO);
            if (cal.seconds == rtc_pkg::LAST_SEC_MIN)
            begin
                next_cal.minutes = bcd_step(cal.minutes, rtc_pkg::LAST_SEC_MIN,
                                            rtc_pkg::FIRST_ZERO);
                if (cal.minutes == rtc_pkg::LAST_SEC_MIN)
                begin
                    next_cal.hours = bcd_step(cal.hours, rtc_pkg::LAST_HOUR,
                                              rtc_pkg::FIRST_ZERO); // RULE_22
                    if (cal.hours == rtc_pkg::LAST_HOUR)
                    begin
                        next_cal.weekday = bcd_step(cal.weekday, rtc_pkg::LAST_WEEKDAY,
                                                    rtc_pkg::FIRST_ZERO); // RULE_01
                        next_cal.day = bcd_step(cal.day, last_day(cal.month, cal.year),
                                                rtc_pkg::FIRST_ONE); // RULE_02 RULE_03
                        if (cal.day == last_day(cal.month, cal.year))
                        begin
                            next_cal.month = bcd_step(cal.month, rtc_pkg::LAST_MONTH,
                                                      rtc_pkg::FIRST_ONE); // RULE_22
                            if (cal.month == rtc_pkg::LAST_MONTH)
                                next_cal.year = bcd_step(cal.year, rtc_pkg::LAST_YEAR,
                                                         rtc_pkg::FIRST_ZERO); // RULE_22
                        end
                    end
                end
            end
        end
        if (wr_counter) // RULE_04 RULE_07 RULE_25
        begin
            case (value_window_pointer)
                rtc_pkg::PTR_MIN_SEC:
                begin
                    if (wr_vh)
                        next_cal.minutes = cpu_req.data & rtc_pkg::MASK_SEC_MIN;
                    else
                        next_cal.seconds = cpu_req.data & rtc_pkg::MASK_SEC_MIN;
                end
                rtc_pkg::PTR_WDAY_HOUR:
                begin
                    if (wr_vh)
                        next_cal.weekday = cpu_req.data & rtc_pkg::MASK_WEEKDAY;
                    else
                        next_cal.hours = cpu_req.data & rtc_pkg::MASK_HOUR_DAY;
                end
                rtc_pkg::PTR_MONTH_DAY:
                begin
                    if (wr_vh)
                        next_cal.month = cpu_req.data & rtc_pkg::MASK_MONTH;
                    else
                        next_cal.day = cpu_req.data & rtc_pkg::MASK_HOUR_DAY;
                end
                default:
                begin
                    if (wr_vl)
                        next_cal.year = cpu_req.data;
                end
            endcase
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            cal <= rtc_pkg::CAL_RESET;
        else
            cal <= next_cal;
    end

    // keyed unlock: 55, AA, then the set must arrive inside the window
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            unlock_state <= rtc_pkg::UNLOCK_IDLE;
            unlock_count <= '0;
        end
        else
        begin
            case (unlock_state)
                rtc_pkg::UNLOCK_IDLE:
                    if (wr_key && cpu_req.data == rtc_pkg::KEY_FIRST)
                        unlock_state <= rtc_pkg::UNLOCK_FIRST;
                rtc_pkg::UNLOCK_FIRST:
                    if (wr_key && cpu_req.data == rtc_pkg::KEY_SECOND)
                    begin
                        unlock_state <= rtc_pkg::UNLOCK_OPEN; // RULE_12
                        unlock_count <= rtc_pkg::UNLOCK_CYCLES;
                    end
                    else if (cpu_req.wr)
                        unlock_state <= rtc_pkg::UNLOCK_IDLE; // RULE_24
                rtc_pkg::UNLOCK_OPEN:
                begin
                    unlock_count <= unlock_count - 3'h1;
                    if (cpu_req.wr || unlock_count == 3'h1)
                        unlock_state <= rtc_pkg::UNLOCK_IDLE; // RULE_12 RULE_24
                end
                default:
                    unlock_state <= rtc_pkg::UNLOCK_IDLE;
            endcase
        end
    end

    // clock configuration: enable and write-enable bits, value pointer
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            clock_module_enable <= 1'b0;
            counter_write_enable <= 1'b0;
            value_window_pointer <= rtc_pkg::PTR_MIN_SEC;
        end
        else if (wr_cfg)
        begin
            value_window_pointer <= cpu_req.data[1:0]; // RULE_14
            if (counter_write_enable)
                clock_module_enable <= cpu_req.data[rtc_pkg::CFG_ENABLE_BIT]; // RULE_21
            if (!cpu_req.data[rtc_pkg::CFG_WREN_BIT])
                counter_write_enable <= 1'b0;
            else if (unlock_state == rtc_pkg::UNLOCK_OPEN)
                counter_write_enable <= 1'b1; // RULE_12
        end
        else if (acc_vh && value_window_pointer != rtc_pkg::PTR_MIN_SEC)
            value_window_pointer <= value_window_pointer - 2'h1; // RULE_15
    end

    // alarm configuration, pointer and value storage
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            alarm_window_pointer <= rtc_pkg::PTR_MIN_SEC;
            alarm_cfg_upper <= '0;
        end
        else if (cpu_req.wr && cpu_req.sel == rtc_pkg::SEL_ALARM_CFG)
        begin
            alarm_window_pointer <= cpu_req.data[1:0]; // RULE_16
            alarm_cfg_upper <= cpu_req.data[7:2];
        end
        else if (acc_ah && alarm_window_pointer != rtc_pkg::PTR_MIN_SEC)
            alarm_window_pointer <= alarm_window_pointer - 2'h1; // RULE_17
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            alarm_minutes <= '0;
            alarm_seconds <= '0;
            alarm_weekday <= '0;
            alarm_hours <= '0;
            alarm_month <= '0;
            alarm_day <= '0;
        end
        else if (counter_write_enable && (wr_ah || wr_al))
        begin
            case (alarm_window_pointer)
                rtc_pkg::PTR_MIN_SEC:
                    if (wr_ah)
                        alarm_minutes <= cpu_req.data & rtc_pkg::MASK_SEC_MIN;
                    else
                        alarm_seconds <= cpu_req.data & rtc_pkg::MASK_SEC_MIN;
                rtc_pkg::PTR_WDAY_HOUR:
                    if (wr_ah)
                        alarm_weekday <= cpu_req.data & rtc_pkg::MASK_WEEKDAY;
                    else
                        alarm_hours <= cpu_req.data & rtc_pkg::MASK_HOUR_DAY;
                rtc_pkg::PTR_MONTH_DAY:
                    if (wr_ah)
                        alarm_month <= cpu_req.data & rtc_pkg::MASK_MONTH;
                    else
                        alarm_day <= cpu_req.data & rtc_pkg::MASK_HOUR_DAY;
                default:
                    alarm_day <= alarm_day;
            endcase
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            drift_calibration_register <= '0;
        else if (cpu_req.wr && cpu_req.sel == rtc_pkg::SEL_CALIB)
            drift_calibration_register <= cpu_req.data; // RULE_18
    end

    // flag raised during the last stretch of each second before the carry
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            safe_access_window_flag <= 1'b0;
        else
            safe_access_window_flag <= clock_module_enable && half_second
                                       && presc >= rtc_pkg::SYNC_START; // RULE_09
    end

    // read data, captured on the read strobe
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            rdata <= '0;
        else if (cpu_req.rd)
        begin
            case (cpu_req.sel)
                rtc_pkg::SEL_CLOCK_CFG:
                    rdata <= {clock_module_enable, 1'b0, counter_write_enable,
                              safe_access_window_flag, half_second, 1'b0,
                              value_window_pointer};
                rtc_pkg::SEL_ALARM_CFG:
                    rdata <= {alarm_cfg_upper, alarm_window_pointer};
                rtc_pkg::SEL_VALUE_HIGH:
                    case (value_window_pointer)
                        rtc_pkg::PTR_MIN_SEC: rdata <= cal.minutes;
                        rtc_pkg::PTR_WDAY_HOUR: rdata <= cal.weekday;
                        rtc_pkg::PTR_MONTH_DAY: rdata <= cal.month;
                        default: rdata <= '0;
                    endcase
                rtc_pkg::SEL_VALUE_LOW:
                    case (value_window_pointer)
                        rtc_pkg::PTR_MIN_SEC: rdata <= cal.seconds;
                        rtc_pkg::PTR_WDAY_HOUR: rdata <= cal.hours;
                        rtc_pkg::PTR_MONTH_DAY: rdata <= cal.day;
                        default: rdata <= cal.year;
                    endcase
                rtc_pkg::SEL_ALARM_HIGH:
                    case (alarm_window_pointer)
                        rtc_pkg::PTR_MIN_SEC: rdata <= alarm_minutes;
                        rtc_pkg::PTR_WDAY_HOUR: rdata <= alarm_weekday;
                        rtc_pkg::PTR_MONTH_DAY: rdata <= alarm_month;
                        default: rdata <= '0;
                    endcase
                rtc_pkg::SEL_ALARM_LOW:
                    case (alarm_window_pointer)
                        rtc_pkg::PTR_MIN_SEC: rdata <= alarm_seconds;
                        rtc_pkg::PTR_WDAY_HOUR: rdata <= alarm_hours;
                        rtc_pkg::PTR_MONTH_DAY: rdata <= alarm_day;
                        default: rdata <= '0;
                    endcase
                rtc_pkg::SEL_CALIB:
                    rdata <= drift_calibration_register;
                default:
                    rdata <= '0;
            endcase
        end
    end

endmodule

//--- sim/bcd_calendar_clock_core_assertions.sv
// Port-level checks for the calendar clock core.
module bcd_calendar_clock_core_assertions (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // inputs
    input wire logic crystal_tick,
    input rtc_pkg::cpu_req_t cpu_req,
    // outputs
    input wire logic [7:0] rdata,
    input wire logic clock_module_enable,
    input wire logic counter_write_enable,
    input wire logic safe_access_window_flag,
    input wire logic half_second,
    input wire logic second_pulse
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    wire logic cfg_wr = cpu_req.wr && cpu_req.sel == rtc_pkg::SEL_CLOCK_CFG;
    wire logic key_wr = cpu_req.wr && cpu_req.sel == rtc_pkg::SEL_UNLOCK_KEY;
    wire logic set_req = cfg_wr && cpu_req.data[5];
    wire logic rd_req = cpu_req.rd;
    sequence key_pair_s;
        key_wr && cpu_req.data == rtc_pkg::KEY_FIRST ##1 !cpu_req.wr
            ##1 key_wr && cpu_req.data == rtc_pkg::KEY_SECOND;
    endsequence
    unlock_open_a: assert property (key_pair_s ##1 !cpu_req.wr ##1 set_req
        |=> counter_write_enable) else $error("write enable not set after keys");
    wren_rise_a: assert property ($rose(counter_write_enable) |-> $past(set_req))
        else $error("write enable rose without a set request");
    wren_clear_a: assert property (cfg_wr && !cpu_req.data[5] |=> !counter_write_enable)
        else $error("write enable not cleared");
    enable_lock_a: assert property ($changed(clock_module_enable)
        |-> $past(cfg_wr) && $past(counter_write_enable)) else $error("enable changed while locked");
    half_run_a: assert property ($rose(half_second) |-> $past(clock_module_enable))
        else $error("half second advanced while disabled");
    pulse_cause_a: assert property (second_pulse |-> $past(clock_module_enable, 2))
        else $error("second pulse while disabled");
    rdata_hold_a: assert property (!$past(rd_req) |-> $stable(rdata))
        else $error("read data changed without a read");
    sync_half_a: assert property (safe_access_window_flag
        |-> half_second || $past(half_second)) else $error("sync flag outside second end");
endmodule

//--- sim/cpu_model.sv
// Processor-side model issuing register requests to the clock core.
module cpu_model (
    // clock
    input wire logic clk,
    // register port
    output rtc_pkg::cpu_req_t cpu_req,
    input wire logic [7:0] rdata
);
    timeunit 1ns;
    timeprecision 100ps;
    initial cpu_req = '0;
    // one-cycle request; released fields show inverted data
    task automatic xfer(input logic w, input rtc_pkg::reg_sel_t s, input logic [7:0] d);
        @(posedge clk);
        #2;
        cpu_req = '{w, !w, s, d};
        @(posedge clk);
        #2;
        cpu_req = '{1'b0, 1'b0, s, ~d};
    endtask
    task automatic wr(input rtc_pkg::reg_sel_t s, input logic [7:0] d);
        xfer(1'b1, s, d);
    endtask
    task automatic rd(input rtc_pkg::reg_sel_t s, output logic [7:0] d);
        xfer(1'b0, s, 8'h00);
        d = rdata;
    endtask
    task automatic unlock(input logic [7:0] cfg);
        wr(rtc_pkg::SEL_UNLOCK_KEY, rtc_pkg::KEY_FIRST);
        wr(rtc_pkg::SEL_UNLOCK_KEY, rtc_pkg::KEY_SECOND);
        wr(rtc_pkg::SEL_CLOCK_CFG, cfg);
    endtask
endmodule

//--- sim/bcd_calendar_clock_core_tb.sv
// Self-checking bench for the calendar clock core.
module bcd_calendar_clock_core_tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk;
    logic rst;
    logic crystal_tick;
    rtc_pkg::cpu_req_t cpu_req;
    logic [7:0] rdata;
    logic en, wren, safe, half, spulse;
    int n_mismatch;
    int num_checks;
    bcd_calendar_clock_core dut_u (.clk(clk), .rst(rst), .crystal_tick(crystal_tick),
        .cpu_req(cpu_req), .rdata(rdata), .clock_module_enable(en),
        .counter_write_enable(wren), .safe_access_window_flag(safe), .half_second(half),
        .second_pulse(spulse));
    cpu_model cpu_u (.clk(clk), .cpu_req(cpu_req), .rdata(rdata));
    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        num_checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // pointer starts at year and steps down through the windows
    task automatic read_all(input logic [7:0] base, input logic [7:0] exp [8]);
        logic [7:0] v;
        cpu_u.wr(rtc_pkg::SEL_CLOCK_CFG, base | 8'h03);
        for (int i = 0; i < 8; i++)
        begin
            cpu_u.rd(i % 2 ? rtc_pkg::SEL_VALUE_HIGH : rtc_pkg::SEL_VALUE_LOW, v);
            check("window", exp[i], v);
        end
    endtask
    task automatic reset_walk();
        check("status", 8'h00, {3'h0, en, wren, safe, half, spulse});
        check("rdata", 8'h00, rdata);
        read_all(8'h00, '{8'h00, 8'h00, 8'h01, 8'h01, 8'h00, 8'h06, 8'h00, 8'h00});
    endtask
    task automatic lock_refusal();
        logic [7:0] v;
        cpu_u.wr(rtc_pkg::SEL_VALUE_LOW, 8'h45);
        cpu_u.wr(rtc_pkg::SEL_CLOCK_CFG, 8'h80);
        check("enable", 8'h00, {7'h00, en});
        cpu_u.wr(rtc_pkg::SEL_UNLOCK_KEY, rtc_pkg::KEY_FIRST);
        cpu_u.wr(rtc_pkg::SEL_VALUE_LOW, 8'h12);
        cpu_u.wr(rtc_pkg::SEL_UNLOCK_KEY, rtc_pkg::KEY_SECOND);
        cpu_u.wr(rtc_pkg::SEL_CLOCK_CFG, 8'h20);
        check("wren", 8'h00, {7'h00, wren});
        cpu_u.wr(rtc_pkg::SEL_UNLOCK_KEY, rtc_pkg::KEY_FIRST);
        cpu_u.wr(rtc_pkg::SEL_UNLOCK_KEY, rtc_pkg::KEY_SECOND);
        repeat (6) @(posedge clk);
        cpu_u.wr(rtc_pkg::SEL_CLOCK_CFG, 8'h20);
        check("wren", 8'h00, {7'h00, wren});
        cpu_u.rd(rtc_pkg::SEL_VALUE_LOW, v);
        check("seconds", 8'h00, v);
        cpu_u.rd(rtc_pkg::SEL_VALUE_LOW, v);
        check("seconds", 8'h00, v);
        cpu_u.wr(rtc_pkg::SEL_ALARM_CFG, 8'h01);
        cpu_u.wr(rtc_pkg::SEL_ALARM_HIGH, 8'h09);
        cpu_u.rd(rtc_pkg::SEL_ALARM_CFG, v);
        check("aptr", 8'h00, v);
        cpu_u.wr(rtc_pkg::SEL_CALIB, 8'h81);
        cpu_u.rd(rtc_pkg::SEL_CALIB, v);
        check("calib", 8'h81, v);
        cpu_u.wr(rtc_pkg::SEL_CALIB, 8'h00);
    endtask
    // load a date at 23:59:59, run one second, read it back
    task automatic roll_case(input logic [7:0] y, m, d, wd, ey, em, ed, ew);
        logic [7:0] w [8] = '{y, 8'h00, d, m, 8'h23, wd, 8'h59, 8'h59};
        cpu_u.unlock(8'h23);
        check("wren", 8'h01, {7'h00, wren});
        for (int i = 0; i < 8; i++)
            cpu_u.wr(i % 2 ? rtc_pkg::SEL_VALUE_HIGH : rtc_pkg::SEL_VALUE_LOW, w[i]);
        cpu_u.wr(rtc_pkg::SEL_CLOCK_CFG, 8'hA0);
        check("enable", 8'h01, {7'h00, en});
        repeat (16400) @(posedge clk);
        #2;
        check("half", 8'h01, {7'h00, half});
        repeat (16338) @(posedge clk);
        #2;
        check("sync", 8'h01, {7'h00, safe});
        repeat (30) @(posedge clk);
        #2;
        check("pulse", 8'h01, {7'h00, spulse});
        cpu_u.wr(rtc_pkg::SEL_CLOCK_CFG, 8'h20);
        read_all(8'h20, '{ey, 8'h00, ed, em, 8'h00, ew, 8'h00, 8'h00});
        cpu_u.wr(rtc_pkg::SEL_CLOCK_CFG, 8'h00);
        check("wren", 8'h00, {7'h00, wren});
    endtask
    initial
    begin
        repeat (80000) @(posedge clk);
        n_mismatch++;
        report_and_stop();
    end
    initial
    begin
        rst = 1'b1;
        crystal_tick = 1'b0;
        repeat (6) @(posedge clk);
        #2;
        rst = 1'b0;
        crystal_tick = 1'b1;
        reset_walk();
        lock_refusal();
        roll_case(8'h99, 8'h12, 8'h31, 8'h06, 8'h00, 8'h01, 8'h01, 8'h00);
        roll_case(8'h24, 8'h02, 8'h28, 8'h03, 8'h24, 8'h02, 8'h29, 8'h04);
        report_and_stop();
    end
endmodule
bind bcd_calendar_clock_core bcd_calendar_clock_core_assertions chk_u (.clk(clk), .rst(rst),
    .crystal_tick(crystal_tick), .cpu_req(cpu_req), .rdata(rdata),
    .clock_module_enable(clock_module_enable), .counter_write_enable(counter_write_enable),
    .safe_access_window_flag(safe_access_window_flag), .half_second(half_second),
    .second_pulse(second_pulse));
